// file: rtl/bsd_regs.vh
// bsd_regs.vh: register offsets, field positions, reset values and mode codes
// for the balancing-switch diagnostic scan block; definitions only.
`ifndef BSD_REGS_VH
`define BSD_REGS_VH

// register byte offsets on the axi4-lite slave
`define BSD_OFF_SCAN_CTRL 6'h00
`define BSD_OFF_CELL_CFG 6'h04
`define BSD_OFF_BAL_EN 6'h08
`define BSD_OFF_ACQ_CFG 6'h0c
`define BSD_OFF_SHORT_THR 6'h10
`define BSD_OFF_LOW_THR 6'h14
`define BSD_OFF_HIGH_THR 6'h18
`define BSD_OFF_ALERT 6'h1c
`define BSD_OFF_STATUS 6'h20

// scan control fields
`define BSD_SCAN_START_BIT 0
`define BSD_CFG_LSB 4
`define BSD_CFG_MSB 6
// cell config fields: polarity [13:0], cell enable [29:16]
`define BSD_POL_LSB 0
`define BSD_CELLEN_LSB 16
// acquisition config fields
`define BSD_MEAS_HI_LSB 0
`define BSD_AUX_LSB 2
`define BSD_DIAG1_LSB 8
`define BSD_DIAG2_LSB 12
`define BSD_ALTSEL_BIT 16
`define BSD_OVS_LSB 20
`define BSD_TOPA_LSB 24
`define BSD_TOPB_LSB 28
// alert register: vector [13:0], summary 16
`define BSD_SUM_BIT 16
// status: busy 0, done 1, ov 4, uv 5, mismatch 6
`define BSD_BUSY_BIT 0
`define BSD_DONE_BIT 1

// scan configuration codes
`define BSD_MODE_SHORT 3'h4
`define BSD_MODE_OPEN 3'h5
`define BSD_MODE_ODD 3'h6
`define BSD_MODE_EVEN 3'h7
// forced sense-wire switch patterns
`define BSD_ODD_PAT 14'h1555
`define BSD_EVEN_PAT 14'h2aaa

// reset values
`define BSD_RST_THR 14'h0000
`define BSD_RST_HIGH 14'h3fff
`define BSD_RST_ALERT 14'h0000

`endif

// file: rtl/bsd_cmp.v
// bsd_cmp.v: one channel's threshold comparison for the diagnostic scan.
// assumes result, thresholds and mode are stable while eval is high.
`timescale 1ns/100ps
module bsd_cmp #(
    parameter W = 14
) (
    input wire aclk,
    input wire aresetn,
    input wire eval,
    input wire short_mode,
    input wire measured,
    input wire [W-1:0] result,
    input wire [W-1:0] short_threshold,
    input wire [W-1:0] low_threshold,
    input wire [W-1:0] high_threshold,
    output reg flag_q
);
    // unmeasured channels stay clear; short uses one bound, others a window
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 1'b0;
        end else if (eval) begin
            if (!measured) begin
                flag_q <= 1'b0;
            end else if (short_mode) begin
                flag_q <= (result < short_threshold);
            end else begin
                flag_q <= (result < low_threshold) || (result > high_threshold);
            end
        end
    end
endmodule

// file: rtl/bsd_top.v
// bsd_top.v: balancing-switch diagnostic scan control with axi4-lite registers.
// assumes the acquisition engine runs on aclk, takes the effective settings
// below while acq_busy is high, and pulses acq_done once with all results valid.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "bsd_regs.vh"

// Functional notes
// - scan config 100 short, 101 open, 110 odd wire, 111 even wire
// - switch alert vector cleared when a switch-mode scan is requested
// - results written at scan done, kept until next switch-mode request
// - short mode flags unipolar channels measuring below short threshold
// - other modes flag below low threshold or above high threshold
// - summary flag becomes OR of all fourteen alert bits at scan end
// - summary clears on clean rescan or software writing zero
// - equal top-cell settings mask alerts above that position
// - overvoltage, undervoltage and mismatch alerts untouched in switch modes
// - switch-short scan forces balancing switch enables to zero
// - short scan: current/block off, aux off, cells unipolar and enabled
// - short scan: diagnostics off, alternate path on, single sample
// - open scan forces bipolar acquisition over alternate path
// - open scan: cells switch-enabled and unipolar, others forced off
// - open scan forces single sample
// - open mode uses configured switch enables, no balancing needed
// - overrides apply only while scanning, normal settings restored after
module bsd_top #(
    parameter N = 14
) (
    input wire aclk,
    input wire aresetn,
    input wire [5:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [5:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire acq_done,
    input wire [N*14-1:0] acq_results,
    input wire acq_ov,
    input wire acq_uv,
    input wire acq_mismatch,
    output reg acq_busy_q,
    output reg [N-1:0] balance_switch_enable_q,
    output reg [N-1:0] cell_enable_q,
    output reg [1:0] measure_enable_primary_q,
    output reg [3:0] measure_enable_aux_q,
    output reg [3:0] diag_sel_a_q,
    output reg [3:0] diag_sel_b_q,
    output reg alt_path_select_q,
    output reg [2:0] oversample_field_q,
    output reg bipolar_force_q
);
    // software configuration registers
    reg [2:0] scan_config_code_q;
    reg [N-1:0] bipolar_position_q;
    reg [N-1:0] cell_cfg_q;
    reg [N-1:0] bal_cfg_q;
    reg [1:0] meas_hi_cfg_q;
    reg [3:0] aux_cfg_q;
    reg [3:0] diag_a_cfg_q;
    reg [3:0] diag_b_cfg_q;
    reg alt_cfg_q;
    reg [2:0] ovs_cfg_q;
    reg [3:0] top_cell_a_q;
    reg [3:0] top_cell_b_q;
    reg [13:0] short_threshold_q;
    reg [13:0] low_threshold_q;
    reg [13:0] high_threshold_q;
    // status
    reg [N-1:0] switch_alert_vector_q;
    reg switch_alert_summary_q;
    reg scan_done_flag_q;
    reg overvoltage_alert_q;
    reg undervoltage_alert_q;
    reg cell_mismatch_alert_q;
    reg [2:0] run_mode_q;
    reg eval_q;

    // scan sequencer, one-hot
    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_EVAL = 3'b100;
    reg [2:0] state_q;

    // axi write channel holding
    reg aw_held_q;
    reg w_held_q;
    reg [5:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire diag_mode = w_data_q[`BSD_CFG_MSB];
    wire run_diag = run_mode_q[2];
    wire run_short = (run_mode_q == `BSD_MODE_SHORT);
    wire run_open = (run_mode_q == `BSD_MODE_OPEN);
    wire run_odd = (run_mode_q == `BSD_MODE_ODD);
    wire run_even = (run_mode_q == `BSD_MODE_EVEN);

    // write is performed once both halves are held and no response pending
    wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    wire start_req = wr_fire && (aw_addr_q[5:2] == `BSD_OFF_SCAN_CTRL >> 2)
        && w_strb_q[0] && w_data_q[`BSD_SCAN_START_BIT] && (state_q == ST_IDLE);

    // effective switch and cell enables while a diagnostic scan runs
    reg [N-1:0] sw_eff;
    reg [N-1:0] cell_eff;
    reg [N-1:0] topmask;
    integer i;
    always @* begin
        topmask = {N{1'b1}};
        for (i = 0; i < N; i = i + 1) begin
            // channel i sits above the top cell when its number exceeds it
            if ((top_cell_a_q == top_cell_b_q) && (i > top_cell_a_q)) begin
                topmask[i] = 1'b0;
            end
        end
        sw_eff = bal_cfg_q;
        cell_eff = cell_cfg_q;
        if (run_short) begin
            sw_eff = {N{1'b0}};
            cell_eff = ~bipolar_position_q & cell_cfg_q;
        end else if (run_open) begin
            sw_eff = bal_cfg_q;
            cell_eff = bal_cfg_q & ~bipolar_position_q;
        end else if (run_odd || run_even) begin
            sw_eff = (run_odd ? `BSD_ODD_PAT : `BSD_EVEN_PAT) & ~bipolar_position_q & topmask;
            cell_eff = sw_eff & ~bipolar_position_q;
        end
    end

    // per-channel comparators, evaluated in the done cycle while running
    wire [N-1:0] cmp_flag;
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : gen_cmp
            bsd_cmp #(.W(14)) u_cmp (
                .aclk(aclk),
                .aresetn(aresetn),
                .eval(acq_done && state_q == ST_RUN),
                .short_mode(run_short),
                .measured(cell_enable_q[g]),
                .result(acq_results[g*14 +: 14]),
                .short_threshold(short_threshold_q),
                .low_threshold(low_threshold_q),
                .high_threshold(high_threshold_q),
                .flag_q(cmp_flag[g])
            );
        end
    endgenerate

    // sequencer: request -> run until done -> capture results
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            run_mode_q <= 3'h0;
            acq_busy_q <= 1'b0;
            eval_q <= 1'b0;
        end else begin
            eval_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_req) begin
                        run_mode_q <= w_data_q[`BSD_CFG_MSB:`BSD_CFG_LSB]; // rides with start
                        acq_busy_q <= 1'b1;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (acq_done) begin
                        acq_busy_q <= 1'b0;
                        eval_q <= 1'b1;
                        state_q <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    run_mode_q <= 3'h0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // effective acquisition settings; normal values outside a diagnostic scan
    always @(posedge aclk) begin
        if (!aresetn) begin
            balance_switch_enable_q <= {N{1'b0}};
            cell_enable_q <= {N{1'b0}};
            measure_enable_primary_q <= 2'h0;
            measure_enable_aux_q <= 4'h0;
            diag_sel_a_q <= 4'h0;
            diag_sel_b_q <= 4'h0;
            alt_path_select_q <= 1'b0;
            oversample_field_q <= 3'h0;
            bipolar_force_q <= 1'b0;
        end else if (run_diag) begin
            balance_switch_enable_q <= sw_eff;
            cell_enable_q <= cell_eff;
            measure_enable_primary_q <= 2'h0;
            measure_enable_aux_q <= 4'h0;
            diag_sel_a_q <= 4'h0;
            diag_sel_b_q <= 4'h0;
            alt_path_select_q <= 1'b1;
            oversample_field_q <= 3'h0;
            bipolar_force_q <= !run_short;
        end else begin
            balance_switch_enable_q <= bal_cfg_q;
            cell_enable_q <= cell_cfg_q;
            measure_enable_primary_q <= meas_hi_cfg_q;
            measure_enable_aux_q <= aux_cfg_q;
            diag_sel_a_q <= diag_a_cfg_q;
            diag_sel_b_q <= diag_b_cfg_q;
            alt_path_select_q <= alt_cfg_q;
            oversample_field_q <= ovs_cfg_q;
            bipolar_force_q <= 1'b0;
        end
    end

    // alert vector, summary and normal-scan alerts; hardware set beats sw clear
    wire sum_wr = wr_fire && (aw_addr_q[5:2] == `BSD_OFF_ALERT >> 2) && w_strb_q[2]
        && !w_data_q[`BSD_SUM_BIT];
    wire stat_wr = wr_fire && (aw_addr_q[5:2] == `BSD_OFF_STATUS >> 2) && w_strb_q[0];
    always @(posedge aclk) begin
        if (!aresetn) begin
            switch_alert_vector_q <= `BSD_RST_ALERT;
            switch_alert_summary_q <= 1'b0;
            scan_done_flag_q <= 1'b0;
            overvoltage_alert_q <= 1'b0;
            undervoltage_alert_q <= 1'b0;
            cell_mismatch_alert_q <= 1'b0;
        end else begin
            if (start_req) begin
                scan_done_flag_q <= 1'b0;
            end else if (eval_q) begin
                scan_done_flag_q <= 1'b1;
            end else if (stat_wr && !w_data_q[`BSD_DONE_BIT]) begin
                scan_done_flag_q <= 1'b0;
            end
            if (start_req && diag_mode) begin
                switch_alert_vector_q <= {N{1'b0}};
            end else if (eval_q && run_diag) begin
                switch_alert_vector_q <= cmp_flag & topmask;
            end
            if (eval_q && run_diag) begin
                switch_alert_summary_q <= |(cmp_flag & topmask);
            end else if (sum_wr) begin
                switch_alert_summary_q <= 1'b0;
            end
            if (eval_q && !run_diag) begin
                overvoltage_alert_q <= acq_ov;
                undervoltage_alert_q <= acq_uv;
                cell_mismatch_alert_q <= acq_mismatch;
            end
        end
    end

    // axi write side: hold address and data in either order, answer with bresp
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 6'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held_q && s_axi_awvalid && !s_axi_awready;
            s_axi_wready <= !w_held_q && s_axi_wvalid && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q > `BSD_OFF_STATUS) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration register writes; all four byte lanes must be strobed
    always @(posedge aclk) begin
        if (!aresetn) begin
            scan_config_code_q <= 3'h0;
            bipolar_position_q <= {N{1'b0}};
            cell_cfg_q <= {N{1'b0}};
            bal_cfg_q <= {N{1'b0}};
            meas_hi_cfg_q <= 2'h0;
            aux_cfg_q <= 4'h0;
            diag_a_cfg_q <= 4'h0;
            diag_b_cfg_q <= 4'h0;
            alt_cfg_q <= 1'b0;
            ovs_cfg_q <= 3'h0;
            top_cell_a_q <= 4'hd;
            top_cell_b_q <= 4'hd;
            short_threshold_q <= `BSD_RST_THR;
            low_threshold_q <= `BSD_RST_THR;
            high_threshold_q <= `BSD_RST_HIGH;
        end else if (wr_fire && (&w_strb_q)) begin
            // whole-word writes only: partial writes are acknowledged and dropped
            case (aw_addr_q)
                `BSD_OFF_SCAN_CTRL: scan_config_code_q <= w_data_q[`BSD_CFG_MSB:`BSD_CFG_LSB];
                `BSD_OFF_CELL_CFG: begin
                    bipolar_position_q <= w_data_q[`BSD_POL_LSB +: 14];
                    cell_cfg_q <= w_data_q[`BSD_CELLEN_LSB +: 14];
                end
                `BSD_OFF_BAL_EN: bal_cfg_q <= w_data_q[13:0];
                `BSD_OFF_ACQ_CFG: begin
                    meas_hi_cfg_q <= w_data_q[`BSD_MEAS_HI_LSB +: 2];
                    aux_cfg_q <= w_data_q[`BSD_AUX_LSB +: 4];
                    diag_a_cfg_q <= w_data_q[`BSD_DIAG1_LSB +: 4];
                    diag_b_cfg_q <= w_data_q[`BSD_DIAG2_LSB +: 4];
                    alt_cfg_q <= w_data_q[`BSD_ALTSEL_BIT];
                    ovs_cfg_q <= w_data_q[`BSD_OVS_LSB +: 3];
                    top_cell_a_q <= w_data_q[`BSD_TOPA_LSB +: 4];
                    top_cell_b_q <= w_data_q[`BSD_TOPB_LSB +: 4];
                end
                `BSD_OFF_SHORT_THR: short_threshold_q <= w_data_q[13:0];
                `BSD_OFF_LOW_THR: low_threshold_q <= w_data_q[13:0];
                `BSD_OFF_HIGH_THR: high_threshold_q <= w_data_q[13:0];
                default: ;
            endcase
        end
    end

    // axi read side: one read at a time, registered data
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `BSD_OFF_SCAN_CTRL: s_axi_rdata <= {25'h0, scan_config_code_q, 4'h0};
                    `BSD_OFF_CELL_CFG: s_axi_rdata <= {2'h0, cell_cfg_q, 2'h0, bipolar_position_q};
                    `BSD_OFF_BAL_EN: s_axi_rdata <= {18'h0, bal_cfg_q};
                    `BSD_OFF_ACQ_CFG: s_axi_rdata <= {top_cell_b_q, top_cell_a_q, 1'b0,
                        ovs_cfg_q, 3'h0, alt_cfg_q, diag_b_cfg_q, diag_a_cfg_q, 2'h0,
                        aux_cfg_q, meas_hi_cfg_q};
                    `BSD_OFF_SHORT_THR: s_axi_rdata <= {18'h0, short_threshold_q};
                    `BSD_OFF_LOW_THR: s_axi_rdata <= {18'h0, low_threshold_q};
                    `BSD_OFF_HIGH_THR: s_axi_rdata <= {18'h0, high_threshold_q};
                    `BSD_OFF_ALERT: s_axi_rdata <= {15'h0, switch_alert_summary_q, 2'h0,
                        switch_alert_vector_q};
                    `BSD_OFF_STATUS: s_axi_rdata <= {25'h0, cell_mismatch_alert_q,
                        undervoltage_alert_q, overvoltage_alert_q, 2'h0, scan_done_flag_q,
                        acq_busy_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2; // unmapped: slverr
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// file: verification/bsd_top_properties.sv
// bsd_top_properties.sv: port-level checks for the diag scan block.
// assumes write address and data arrive together, as the bench drives them.
`timescale 1ns/100ps
module bsd_props #(
    parameter N = 14
) (
    input wire aclk,
    input wire aresetn,
    input wire [5:0] s_axi_awaddr,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire acq_done,
    input wire acq_busy_q,
    input wire [N-1:0] balance_switch_enable_q,
    input wire [1:0] measure_enable_primary_q,
    input wire alt_path_select_q,
    input wire [2:0] oversample_field_q,
    input wire bipolar_force_q
);
    reg [2:0] mode_q;
    // code of the scan in flight; a start while busy is dropped
    always @(posedge aclk) begin
        if (!aresetn)
            mode_q <= 3'h0;
        else if (s_axi_wvalid && s_axi_wready && s_axi_awaddr == 6'h00 && s_axi_wdata[0]
                && !acq_busy_q)
            mode_q <= s_axi_wdata[6:4];
    end
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // overrides lag busy by a cycle, so switch checks start at the third busy cycle
    ovr_bipolar_a: assert property (bipolar_force_q |-> alt_path_select_q &&
        oversample_field_q == 3'h0 && measure_enable_primary_q == 2'h0)
        else $error("bipolar scan without its forced settings");
    short_sw_off_a: assert property (acq_busy_q && $past(acq_busy_q) &&
        $past(acq_busy_q, 2) && mode_q == 3'h4 |-> balance_switch_enable_q == {N{1'b0}})
        else $error("switches on during short scan");
    sense_pattern_a: assert property (acq_busy_q && $past(acq_busy_q) &&
        $past(acq_busy_q, 2) && mode_q[2:1] == 2'b11 |->
        (balance_switch_enable_q & (mode_q[0] ? 14'h1555 : 14'h2aaa)) == 14'h0)
        else $error("sense scan closed a switch outside its pattern");
    busy_drop_a: assert property (acq_done |=> !acq_busy_q)
        else $error("busy stayed high after scan done");
    scan_restore_a: assert property (!acq_busy_q [*5] |-> !bipolar_force_q)
        else $error("bipolar override held after the scan");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped before taken");
endmodule

bind bsd_top bsd_props #(.N(N)) u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .acq_done(acq_done),
    .acq_busy_q(acq_busy_q), .balance_switch_enable_q(balance_switch_enable_q),
    .measure_enable_primary_q(measure_enable_primary_q),
    .alt_path_select_q(alt_path_select_q), .oversample_field_q(oversample_field_q),
    .bipolar_force_q(bipolar_force_q));

// file: verification/test_balance_switch_diag_scan.sv
// test_balance_switch_diag_scan.sv: random and corner scans of the diag scan block.
// the bench plays the acquisition engine itself; registers go over axi4-lite.
`timescale 1ns/100ps
module test_balance_switch_diag_scan;
    reg aclk, aresetn, awv, wv, br, arv, rr, done, ov, sum;
    reg [5:0] awa, ara;
    reg [31:0] wd, acq, rd, st;
    reg [195:0] res;
    reg [13:0] pol, cen, ben, sthr, lthr, hthr, alert;
    reg [95:0] rnd;
    reg [223:0] big;
    reg [1:0] rsp;
    wire awr, wrr, bv, arr, rv, busy, alt, bip;
    wire [1:0] bresp, rresp, prim;
    wire [31:0] rdata;
    wire [13:0] swen, cellen;
    wire [3:0] aux, dga, dgb;
    wire [2:0] ovs;
    integer n_mismatch, n_tests, cyc, i, k;

    bsd_top #(.N(14)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .acq_done(done),
        .acq_results(res), .acq_ov(ov), .acq_uv(ov), .acq_mismatch(ov), .acq_busy_q(busy),
        .balance_switch_enable_q(swen), .cell_enable_q(cellen),
        .measure_enable_primary_q(prim), .measure_enable_aux_q(aux), .diag_sel_a_q(dga),
        .diag_sel_b_q(dgb), .alt_path_select_q(alt), .oversample_field_q(ovs),
        .bipolar_force_q(bip));

    // 10 mhz clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // runaway guard; a normal run is well under two thousand cycles
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // address and data offered together, each dropped once taken
    task wr(input [5:0] a, input [31:0] d);
        reg ao, wo;
        begin
            @(posedge aclk);
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            ao = 1'b0;
            wo = 1'b0;
            while (!(ao && wo)) begin
                @(posedge aclk);
                ao = ao | (awr === 1'b1);
                wo = wo | (wrr === 1'b1);
                awv <= !ao;
                wv <= !wo;
            end
            while (bv !== 1'b1) @(posedge aclk);
            br <= 1'b1;
            @(posedge aclk);
            br <= 1'b0;
            rsp = bresp;
        end
    endtask

    // ready held back on purpose so the slave must keep its answer up
    task rdr(input [5:0] a);
        begin
            @(posedge aclk);
            ara <= a;
            arv <= 1'b1;
            while (arr !== 1'b1) @(posedge aclk);
            arv <= 1'b0;
            while (rv !== 1'b1) @(posedge aclk);
            rr <= 1'b1;
            @(posedge aclk);
            rr <= 1'b0;
            rd = rdata;
            rsp = rresp;
        end
    endtask

    function [13:0] topm(input [31:0] c);
        topm = (c[27:24] == c[31:28] && c[27:24] < 4'hd) ?
            ~(14'h3fff << (c[27:24] + 4'h1)) : 14'h3fff;
    endfunction

    function [13:0] meas(input [2:0] m);
        case (m)
            3'h4: meas = ~pol & cen;
            3'h5: meas = ben & ~pol;
            3'h6: meas = 14'h1555 & ~pol & topm(acq);
            default: meas = 14'h2aaa & ~pol & topm(acq);
        endcase
    endfunction

    function [13:0] flags(input [2:0] m);
        integer j;
        reg [13:0] r;
        begin
            for (j = 0; j < 14; j = j + 1) begin
                r = res[j*14 +: 14];
                flags[j] = (m == 3'h4) ? r < sthr : (r < lthr || r > hthr);
            end
            flags = flags & meas(m) & topm(acq);
        end
    endfunction

    // configure, start, check overrides, finish, check results and restore
    task scan(input [2:0] m);
        begin
            wr(6'h04, {2'h0, cen, 2'h0, pol});
            wr(6'h08, {18'h0, ben});
            wr(6'h0c, acq);
            wr(6'h10, {18'h0, sthr});
            wr(6'h14, {18'h0, lthr});
            wr(6'h18, {18'h0, hthr});
            wr(6'h00, {25'h0, m, 4'h1});
            while (busy !== 1'b1) @(posedge aclk);
            repeat (2) @(posedge aclk);
            if (m[2]) begin
                chk({bip, alt, ovs, prim, aux, dga, dgb}, {m != 3'h4, 1'b1, 17'h0});
                chk({swen, cellen}, {m == 3'h4 ? 14'h0 : (m == 3'h5 ? ben : meas(m)),
                    meas(m)});
                rdr(6'h1c);
                chk(rd, {15'h0, sum, 16'h0});
            end
            @(posedge aclk);
            done <= 1'b1;
            @(posedge aclk);
            done <= 1'b0;
            repeat (5) @(posedge aclk);
            chk({swen, cellen, alt, ovs, bip}, {ben, cen, acq[16], acq[22:20], 1'b0});
            alert = m[2] ? flags(m) : alert;
            sum = m[2] ? |alert : sum;
            st = m[2] ? st : {25'h0, {3{ov}}, 4'h2};
            rdr(6'h1c);
            chk(rd, {15'h0, sum, 2'h0, alert});
            rdr(6'h20);
            chk(rd, st);
            $display("scan with code %0d finished", m);
        end
    endtask

    task wrap_up;
        begin
            $display("compares %0d, mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    initial begin
        n_mismatch = 0;
        n_tests = 0;
        cyc = 0;
        aresetn = 1'b0;
        {awv, wv, br, arv, rr, done, ov, sum} = 8'h0;
        {awa, ara, wd, acq, st, res, pol, cen, ben, sthr, lthr, hthr, alert} = 0;
        k = $urandom(32'hd089aa09);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(6'h18);
        chk(rd, 32'h3fff);
        rdr(6'h0c);
        chk(rd, 32'hdd000000);
        rdr(6'h24);
        chk(rsp, 2'h2);
        wr(6'h3c, 32'h0);
        chk(rsp, 2'h2);
        ov <= 1'b1;
        scan(3'h0);
        // first four scans flag every measured channel, the rest are random
        for (i = 0; i < 16; i = i + 1) begin
            rnd = {$urandom, $urandom, $urandom};
            {pol, cen, ben, sthr, lthr, hthr} = rnd[83:0];
            {sthr, lthr} = i < 4 ? {14'h1, 14'h1} : {sthr, lthr};
            acq = $urandom;
            acq[31:28] = i[0] ? acq[27:24] : acq[31:28];
            for (k = 0; k < 7; k = k + 1)
                big[k*32 +: 32] = $urandom;
            res <= i < 4 ? 196'h0 : big[195:0];
            ov <= rnd[95];
            scan(3'h4 + i[1:0]);
        end
        ov <= 1'b0;
        scan(3'h0);
        wr(6'h1c, 32'h0);
        sum = 1'b0;
        rdr(6'h1c);
        chk(rd, {18'h0, alert});
        // alerts again, then a clean rescan sitting exactly on the thresholds
        {pol, sthr, lthr, hthr} = {14'h0, {3{14'h100}}};
        res <= 196'h0;
        scan(3'h6);
        res <= {14{14'h100}};
        scan(3'h5);
        wrap_up;
    end
endmodule
